// ===== logic/cantx_top.sv
// Channel transmit storage: FIFO interval timers, buffer links, queues, history
//
// How it works
// RQ1: Each FIFO runs as receive or transmit FIFO per its mode field.
// RQ2: Interval timer spaces sends only in transmit or gateway mode.
// RQ3: Source 00 ticks every twice-prescaler peripheral clocks.
// RQ4: Source 10 divides the prescaled tick by ten more.
// RQ5: Source with low bit set counts nominal bit times.
// RQ6: Eight-bit interval multiplier sets the tick count per interval.
// RQ7: Transmit or gateway FIFO sends via its one linked buffer.
// RQ8: Software links no two FIFOs to the same buffer.
// RQ9: Software never gives a linked buffer to a queue.
// RQ10: Sixty-four transmit buffers per channel, any use.
// RQ11: Software zeroes control and irq enable of linked or queued buffers.
// RQ12: Per-buffer enable gates its transmit complete interrupt.
// RQ13: Channel transmit interrupt ORs five transmit sources.
// RQ14: Four queues, each up to thirty-two buffers.
// RQ15: Depth 0 or 3 to 32; fixed fill directions per queue.
// RQ16: Queue 3 refuses gateway, takes DMA; others refuse DMA.
// RQ17: Software selects identifier priority whenever queues are used.
// RQ18: Queue interrupt on becoming empty or on every send.
// RQ19: Overwrite mode replaces same-ID message, else new one is queued if there is room.
// RQ20: History holds up to sixty-four entries.
// RQ21: History logs FIFO/queue or all sources, per-message flag.
// RQ22: History interrupt at three quarters full or every entry.
// RQ23: FIFO interrupt mode selects empty-after-send or every send.
// RQ24: After each FIFO send the timer reloads and holds the next.
`timescale 1ns/1ps
module cantx_top (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [11:0]           paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic                       pready_o,
	output logic [31:0]                prdata_o,
	output logic                       pslverr_o,
	input  wire logic                  bit_tick_i,
	input  wire cantx_pkg::cantx_done_t done_i,
	input  wire cantx_pkg::cantx_push_t push_i,
	output logic [2:0]                 fifo_go_o,
	output logic [2:0]                 fifo_is_rx_o,
	output logic [2:0][5:0]            fifo_link_o,
	output logic [3:0][5:0]            queue_head_o,
	output logic [3:0]                 queue_busy_o,
	output logic                       push_ok_o,
	output logic                       push_drop_o,
	output logic [5:0]                 push_buf_o,
	output logic                       tx_irq_o
);
	import cantx_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [5:0] slot_buf(input logic [1:0] q, input logic [4:0] i);
		case (q)
			2'h0: slot_buf = {1'b0, i};
			2'h1: slot_buf = {1'b0, 5'h1F - i};
			2'h2: slot_buf = {1'b1, i};
			default: slot_buf = {1'b1, 5'h1F - i};
		endcase
	endfunction : slot_buf

	function automatic logic route_ok(input logic [1:0] q, input cantx_src_t s);
		route_ok = (q == 2'h3) ? (s != S_GW) : (s != S_DMA);
	endfunction : route_ok

	function automatic logic [4:0] wrap(input logic [4:0] p, input logic [5:0] d);
		wrap = (6'(p) + 6'h01 >= d) ? 5'h00 : p + 5'h01;
	endfunction : wrap

	////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [15:0]      presc_r;
	cantx_mode_t      fmode_r [3];
	logic [2:0]       fen_r, firqm_r, fss_r, fref_r;
	logic [5:0]       flink_r [3];
	logic [7:0]       fitv_r [3];
	logic [3:0]       qen_r, qirqm_r, qow_r;
	logic [5:0]       qdep_r [4];
	logic             hen_r, hall_r, hirqm_r;
	logic [63:0]      ien_r; // [RQ10]
	logic [4:0]       stat_r, ev;
	logic [31:0]      rdata_r;
	logic             err_r;
	logic [5:0]       qcnt [4];
	logic [6:0]       hcnt_r;
	logic [7:0]       hhead;

	logic setup, acc, wr, rd_hist, bad;
	assign setup    = psel_i & ~penable_i;
	assign acc      = psel_i & penable_i;
	assign bad      = (paddr_i > A_STAT) | (paddr_i[1:0] != 2'h0);
	assign wr       = acc & pwrite_i & ~err_r;
	assign rd_hist  = acc & ~pwrite_i & ~err_r & (paddr_i == A_HDATA);
	assign pready_o = acc;
	assign prdata_o = rdata_r;
	assign pslverr_o = err_r;
	assign tx_irq_o = |stat_r; // [RQ13]

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			presc_r <= R_PRESC;
			fen_r <= 3'h0;
			firqm_r <= 3'h0;
			fss_r <= 3'h0;
			fref_r <= 3'h0;
			qen_r <= 4'h0;
			qirqm_r <= 4'h0;
			qow_r <= 4'h0;
			hen_r <= 1'b0;
			hall_r <= 1'b0;
			hirqm_r <= 1'b0;
			ien_r <= 64'h0;
			for (int k = 0; k < 3; k++) begin
				fmode_r[k] <= M_RX;
				flink_r[k] <= 6'h00;
				fitv_r[k] <= 8'h00;
			end
			for (int m = 0; m < 4; m++) begin
				qdep_r[m] <= 6'h00;
			end
		end else if (wr) begin
			if (paddr_i == A_PRESC) presc_r <= pwdata_i[15:0];
			if (paddr_i == A_IEN_LO) ien_r[31:0] <= pwdata_i; // [RQ12]
			if (paddr_i == A_IEN_HI) ien_r[63:32] <= pwdata_i;
			if (paddr_i == A_HIST) begin
				hen_r <= pwdata_i[H_EN];
				hall_r <= pwdata_i[H_ALL];
				hirqm_r <= pwdata_i[H_IRQM];
			end
			for (int k = 0; k < 3; k++) begin
				if (paddr_i == A_FIFO0 + 12'(4 * k)) begin
					fen_r[k] <= pwdata_i[F_EN];
					fmode_r[k] <= cantx_mode_t'(pwdata_i[F_MODE +: 2]); // [RQ1]
					firqm_r[k] <= pwdata_i[F_IRQM];
					fss_r[k] <= pwdata_i[F_SS];
					fref_r[k] <= pwdata_i[F_REF];
					flink_r[k] <= pwdata_i[F_LINK +: 6];
					fitv_r[k] <= pwdata_i[F_ITV +: 8]; // [RQ6]
				end
			end
			for (int m = 0; m < 4; m++) begin
				if (paddr_i == A_QUEUE0 + 12'(4 * m)) begin
					qen_r[m] <= pwdata_i[Q_EN];
					qirqm_r[m] <= pwdata_i[Q_IRQM];
					qow_r[m] <= pwdata_i[Q_OW];
					qdep_r[m] <= pwdata_i[Q_DEP +: 6];
				end
			end
		end
	end

	// Read data and error are caught in the setup phase, so access needs no wait
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_r <= 32'h0;
			err_r <= 1'b0;
		end else if (setup) begin
			err_r <= bad;
			rdata_r <= 32'h0;
			if (paddr_i == A_PRESC) rdata_r <= {16'h0, presc_r};
			if (paddr_i == A_IEN_LO) rdata_r <= ien_r[31:0];
			if (paddr_i == A_IEN_HI) rdata_r <= ien_r[63:32];
			if (paddr_i == A_STAT) rdata_r <= {27'h0, stat_r};
			if (paddr_i == A_HIST)
				rdata_r <= {17'h0, hcnt_r, 5'h0, hirqm_r, hall_r, hen_r};
			if (paddr_i == A_HDATA)
				rdata_r <= {23'h0, hcnt_r != 7'h0, hhead};
			for (int k = 0; k < 3; k++) begin
				if (paddr_i == A_FIFO0 + 12'(4 * k))
					rdata_r <= {8'h0, fitv_r[k], 2'h0, flink_r[k], 2'h0, fref_r[k],
						fss_r[k], firqm_r[k], fmode_r[k], fen_r[k]};
			end
			for (int m = 0; m < 4; m++) begin
				if (paddr_i == A_QUEUE0 + 12'(4 * m))
					rdata_r <= {10'h0, qcnt[m], 2'h0, qdep_r[m], 5'h0, qow_r[m],
						qirqm_r[m], qen_r[m]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interval tick sources
	logic [16:0] pre_cnt_r;
	logic [3:0]  div10_r;
	logic        tick_base, tick_ten;
	logic [16:0] pre_top;
	assign pre_top   = (presc_r == 16'h0) ? 17'h1 : {presc_r, 1'b0} - 17'h1;
	assign tick_base = (pre_cnt_r == 17'h0); // [RQ3]
	assign tick_ten  = tick_base & (div10_r == 4'h0); // [RQ4]

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pre_cnt_r <= 17'h0;
			div10_r <= 4'h0;
		end else begin
			pre_cnt_r <= tick_base ? pre_top : pre_cnt_r - 17'h1; // [RQ3]
			if (tick_base)
				div10_r <= (div10_r == 4'h0) ? N_DIV10 - 4'h1 : div10_r - 4'h1; // [RQ4]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// FIFO interval timers and links
	logic [2:0] fifo_ev;
	for (genvar gk = 0; gk < 3; gk++) begin : g_fifo
		logic [7:0] tmr_r;
		logic       txlike, sent, tick;
		assign txlike = fen_r[gk] & (fmode_r[gk] == M_TX | fmode_r[gk] == M_GW); // [RQ1]
		assign sent = done_i.valid & done_i.kind == K_FIFO & done_i.idx == 6'(gk);
		assign tick = fss_r[gk] ? bit_tick_i : (fref_r[gk] ? tick_ten : tick_base); // [RQ5]
		assign fifo_go_o[gk] = txlike & (tmr_r == 8'h0); // [RQ2]
		assign fifo_is_rx_o[gk] = fmode_r[gk] == M_RX; // [RQ1]
		assign fifo_link_o[gk] = flink_r[gk]; // [RQ7]
		assign fifo_ev[gk] = sent & txlike & ~done_i.abort
			& (firqm_r[gk] | done_i.empty); // [RQ23]

		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) tmr_r <= 8'h0;
			else if (!txlike) tmr_r <= 8'h0; // [RQ2]
			else if (sent) tmr_r <= fitv_r[gk]; // [RQ24]
			else if (tick && tmr_r != 8'h0) tmr_r <= tmr_r - 8'h1;
		end

		property p_rx_idle;
			@(posedge clk_i) disable iff (rst_i) fmode_r[gk] == M_RX |-> !fifo_go_o[gk];
		endproperty
		a_rx_idle: assert property (p_rx_idle) else $error("rx FIFO let go"); // [RQ1]
		property p_holdoff;
			@(posedge clk_i) disable iff (rst_i)
			sent && txlike && fitv_r[gk] != 8'h0 |=> !fifo_go_o[gk];
		endproperty
		a_holdoff: assert property (p_holdoff) else $error("no hold off"); // [RQ24]
		property p_bit_src;
			@(posedge clk_i) disable iff (rst_i)
			fss_r[gk] && !bit_tick_i && !sent && txlike |=> $stable(tmr_r);
		endproperty
		a_bit_src: assert property (p_bit_src) else $error("timer moved"); // [RQ5]
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit queues
	logic [3:0] q_ok, q_drop, q_ev;
	logic [5:0] q_buf [4];
	for (genvar gq = 0; gq < 4; gq++) begin : g_q
		logic [28:0] ids_r [32];
		logic [4:0]  rd_r, wr_r, hit_at, off;
		logic [5:0]  cnt_r;
		logic        live, mine, pop, hit, app;
		assign live = qen_r[gq] & qdep_r[gq] >= Q_MIN & qdep_r[gq] <= Q_MAX; // [RQ15]
		assign mine = push_i.valid & push_i.q == 2'(gq);
		assign pop  = done_i.valid & done_i.kind == K_QUEUE
			& done_i.idx[1:0] == 2'(gq) & cnt_r != 6'h0;
		assign app  = mine & live & route_ok(2'(gq), push_i.src) & ~(hit & qow_r[gq])
			& cnt_r < qdep_r[gq]; // [RQ16]
		assign q_ok[gq] = app | (mine & live & route_ok(2'(gq), push_i.src)
			& hit & qow_r[gq]); // [RQ19]
		assign q_drop[gq] = mine & ~q_ok[gq];
		assign q_buf[gq] = slot_buf(2'(gq), (hit & qow_r[gq]) ? hit_at : wr_r);
		assign qcnt[gq] = cnt_r;
		assign queue_head_o[gq] = slot_buf(2'(gq), rd_r); // [RQ15]
		assign queue_busy_o[gq] = cnt_r != 6'h0;
		assign q_ev[gq] = pop & (qirqm_r[gq] | (cnt_r == 6'h1 & ~app)); // [RQ18]

		// Full scan costs 32 comparators per queue; fine for 32 slots
		always_comb begin
			hit = 1'b0;
			hit_at = 5'h0;
			off = 5'h0;
			for (int i = 0; i < 32; i++) begin
				off = (5'(i) >= rd_r) ? 5'(i) - rd_r : 5'(6'(i) + qdep_r[gq] - 6'(rd_r));
				// Slots past the depth keep stale identifiers from earlier use
				if (!hit && 6'(i) < qdep_r[gq] && 6'(off) < cnt_r
					&& ids_r[i] == push_i.id) begin
					hit = 1'b1;
					hit_at = 5'(i);
				end
			end
		end

		always_ff @(posedge clk_i) begin
			if (q_ok[gq]) ids_r[q_buf[gq][5] ? (gq == 3 ? 5'h1F - q_buf[gq][4:0]
				: q_buf[gq][4:0]) : (gq == 1 ? 5'h1F - q_buf[gq][4:0]
				: q_buf[gq][4:0])] <= push_i.id; // [RQ19]
		end

		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				rd_r <= 5'h0;
				wr_r <= 5'h0;
				cnt_r <= 6'h0;
			end else if (!live) begin
				rd_r <= 5'h0;
				wr_r <= 5'h0;
				cnt_r <= 6'h0;
			end else begin
				if (app) wr_r <= wrap(wr_r, qdep_r[gq]);
				if (pop) rd_r <= wrap(rd_r, qdep_r[gq]);
				cnt_r <= cnt_r + 6'(app) - 6'(pop); // [RQ14]
			end
		end

		property p_depth;
			@(posedge clk_i) disable iff (rst_i)
			cnt_r <= Q_MAX && ($past(live) || cnt_r == 6'h0);
		endproperty
		a_depth: assert property (p_depth) else $error("queue overfilled"); // [RQ15]
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			push_ok_o <= 1'b0;
			push_drop_o <= 1'b0;
			push_buf_o <= 6'h0;
		end else begin
			push_ok_o <= q_ok[push_i.q];
			push_drop_o <= q_drop[push_i.q]; // [RQ16]
			push_buf_o <= q_buf[push_i.q];
		end
	end

	sequence s_gw_to_q3;
		push_i.valid && push_i.q == 2'h3 && push_i.src == S_GW;
	endsequence
	property p_q3_no_gw;
		@(posedge clk_i) disable iff (rst_i) s_gw_to_q3 |=> push_drop_o && !push_ok_o;
	endproperty
	a_q3_no_gw: assert property (p_q3_no_gw) else $error("gateway reached q3"); // [RQ16]

	////////////////////////////////////////////////////////////////////////////
	// Transmit history
	logic [7:0] hist_r [64];
	logic [5:0] hwp_r, hrp_r;
	logic       hpush, hpop;
	assign hpush = done_i.valid & hen_r & done_i.log_it & ~done_i.abort
		& (done_i.kind != K_BUF | hall_r) & hcnt_r < H_DEPTH; // [RQ21]
	assign hpop  = rd_hist & hcnt_r != 7'h0;
	assign hhead = hist_r[hrp_r];

	always_ff @(posedge clk_i) begin
		if (hpush) hist_r[hwp_r] <= {done_i.kind, done_i.idx}; // [RQ20]
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hwp_r <= 6'h0;
			hrp_r <= 6'h0;
			hcnt_r <= 7'h0;
		end else begin
			if (hpush) hwp_r <= hwp_r + 6'h1;
			if (hpop) hrp_r <= hrp_r + 6'h1;
			hcnt_r <= hcnt_r + 7'(hpush) - 7'(hpop); // [RQ20]
		end
	end

	property p_hist_cap;
		@(posedge clk_i) disable iff (rst_i) hcnt_r == H_DEPTH |=> hcnt_r <= H_DEPTH;
	endproperty
	a_hist_cap: assert property (p_hist_cap) else $error("history over 64"); // [RQ20]

	////////////////////////////////////////////////////////////////////////////
	// Channel transmit interrupt sources
	logic bufdone;
	assign bufdone = done_i.valid & done_i.kind == K_BUF & ien_r[done_i.idx]; // [RQ12]
	assign ev[ST_DONE]  = bufdone & ~done_i.abort;
	assign ev[ST_ABORT] = bufdone & done_i.abort;
	assign ev[ST_FIFO]  = |fifo_ev;
	assign ev[ST_QUEUE] = |q_ev;
	assign ev[ST_HIST]  = hpush & (hirqm_r | hcnt_r == H_3QUART - 7'h1); // [RQ22]

	// Write one to clear; a new event in the same cycle wins
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) stat_r <= 5'h0;
		else stat_r <= (stat_r & ~((wr && paddr_i == A_STAT) ? pwdata_i[4:0] : 5'h0))
			| ev; // [RQ13]
	end

	sequence s_buf_done;
		done_i.valid && done_i.kind == K_BUF && !done_i.abort;
	endsequence
	property p_ien_gate;
		@(posedge clk_i) disable iff (rst_i)
		s_buf_done and ien_r[done_i.idx] |=> stat_r[ST_DONE] && tx_irq_o;
	endproperty
	a_ien_gate: assert property (p_ien_gate) else $error("complete irq lost"); // [RQ12]
	property p_presc;
		@(posedge clk_i) disable iff (rst_i)
		tick_base && presc_r >= 16'h2 && $stable(presc_r) |=> !tick_base [*3];
	endproperty
	a_presc: assert property (p_presc) else $error("prescale too fast"); // [RQ3]
	property p_ten;
		@(posedge clk_i) disable iff (rst_i) tick_ten |-> tick_base ##1 !tick_ten;
	endproperty
	a_ten: assert property (p_ten) else $error("div10 tick off base"); // [RQ4]
	property p_hist_irq;
		@(posedge clk_i) disable iff (rst_i)
		hpush && hirqm_r |=> stat_r[ST_HIST];
	endproperty
	a_hist_irq: assert property (p_hist_irq) else $error("history irq missed"); // [RQ22]

endmodule : cantx_top

// ===== logic/cantx_pkg.sv
// Shared constants and types of the channel transmit storage block
package cantx_pkg;
	// Register byte offsets
	localparam logic [11:0] A_PRESC  = 12'h000;
	localparam logic [11:0] A_FIFO0  = 12'h004;
	localparam logic [11:0] A_QUEUE0 = 12'h010;
	localparam logic [11:0] A_HIST   = 12'h020;
	localparam logic [11:0] A_HDATA  = 12'h024;
	localparam logic [11:0] A_IEN_LO = 12'h028;
	localparam logic [11:0] A_IEN_HI = 12'h02C;
	localparam logic [11:0] A_STAT   = 12'h030;
	// FIFO config fields
	localparam int F_EN   = 0;
	localparam int F_MODE = 1;
	localparam int F_IRQM = 3;
	localparam int F_SS   = 4;
	localparam int F_REF  = 5;
	localparam int F_LINK = 8;
	localparam int F_ITV  = 16;
	// Queue config fields
	localparam int Q_EN   = 0;
	localparam int Q_IRQM = 1;
	localparam int Q_OW   = 2;
	localparam int Q_DEP  = 8;
	localparam int Q_CNT  = 16;
	// History config fields
	localparam int H_EN   = 0;
	localparam int H_ALL  = 1;
	localparam int H_IRQM = 2;
	localparam int H_CNT  = 8;
	localparam int H_VLD  = 8;
	// Status bits
	localparam int ST_DONE  = 0;
	localparam int ST_ABORT = 1;
	localparam int ST_FIFO  = 2;
	localparam int ST_QUEUE = 3;
	localparam int ST_HIST  = 4;
	// Reset values and counts
	localparam logic [15:0] R_PRESC   = 16'h0001;
	localparam logic [3:0]  N_DIV10   = 4'hA;
	localparam logic [5:0]  Q_MIN     = 6'h03;
	localparam logic [5:0]  Q_MAX     = 6'h20;
	localparam logic [6:0]  H_DEPTH   = 7'h40;
	localparam logic [6:0]  H_3QUART  = 7'h30;

	typedef enum logic [1:0] {M_RX = 2'h0, M_TX = 2'h1, M_GW = 2'h2} cantx_mode_t;
	typedef enum logic [1:0] {K_BUF = 2'h0, K_FIFO = 2'h1, K_QUEUE = 2'h2} cantx_kind_t;
	typedef enum logic [1:0] {S_CPU = 2'h0, S_GW = 2'h1, S_DMA = 2'h2} cantx_src_t;

	typedef struct packed {
		logic        valid;
		cantx_kind_t kind;
		logic [5:0]  idx;
		logic        abort;
		logic        empty;
		logic        log_it;
	} cantx_done_t;

	typedef struct packed {
		logic        valid;
		cantx_src_t  src;
		logic [1:0]  q;
		logic [28:0] id;
	} cantx_push_t;
endpackage : cantx_pkg

// ===== verification/cantx_engine_model.sv
// Stand-in for the transmit engine: completion reports and nominal bit ticks
`timescale 1ns/1ps
module cantx_engine_model (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire cantx_pkg::cantx_done_t req_i,
	input  wire logic [3:0]             lat_i,
	input  wire logic [7:0]             bit_per_i,
	output cantx_pkg::cantx_done_t      done_o,
	output logic                        bit_tick_o
);
	import cantx_pkg::*;
	cantx_done_t job_r;
	logic [3:0]  wait_r;
	logic [7:0]  bit_cnt_r;
	////////////////////////////////////////////////////////////
	// One report per request, after a chosen latency
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			job_r  <= '0;
			wait_r <= 4'h0;
			done_o <= '0;
		end else begin
			done_o <= '0;
			if (req_i.valid) begin
				job_r  <= req_i;
				wait_r <= lat_i;
			end else if (job_r.valid && wait_r == 4'h0) begin
				done_o      <= job_r;
				job_r.valid <= 1'b0;
			end else if (job_r.valid) begin
				wait_r <= wait_r - 4'h1;
			end
		end
	end
	////////////////////////////////////////////////////////////
	// Bit time runs free; the channel bit clock never pauses
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bit_cnt_r  <= 8'h00;
			bit_tick_o <= 1'b0;
		end else begin
			bit_cnt_r  <= (bit_cnt_r >= bit_per_i - 8'h01) ? 8'h00 : bit_cnt_r + 8'h01;
			bit_tick_o <= (bit_cnt_r == bit_per_i - 8'h01);
		end
	end
endmodule : cantx_engine_model

// ===== verification/cantx_top_tb.sv
// Self-checking bench of the channel transmit storage block
`timescale 1ns/1ps
module cantx_top_tb;
	import cantx_pkg::*;
	logic            clk_i, rst_i, psel, penable, pwrite, pready, pslverr, err_s;
	logic [11:0]     paddr;
	logic [31:0]     pwdata, prdata, rd;
	logic            bit_tick, push_ok, push_drop, tx_irq, ok_s, dr_s;
	logic [2:0]      fifo_go, fifo_rx;
	logic [2:0][5:0] fifo_link;
	logic [3:0][5:0] q_head;
	logic [3:0]      q_busy, lat;
	logic [5:0]      push_buf, bf_s;
	logic [7:0]      bit_per;
	logic [28:0]     id0;
	logic [1:0]      srcs [4];
	cantx_done_t     req, done_w;
	cantx_push_t     push;
	cantx_src_t      cs;
	int              errors, n_tests, presc, mult, t, n;

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	cantx_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
		.prdata_o(prdata), .pslverr_o(pslverr), .bit_tick_i(bit_tick), .done_i(done_w),
		.push_i(push), .fifo_go_o(fifo_go), .fifo_is_rx_o(fifo_rx), .fifo_link_o(fifo_link),
		.queue_head_o(q_head), .queue_busy_o(q_busy), .push_ok_o(push_ok),
		.push_drop_o(push_drop), .push_buf_o(push_buf), .tx_irq_o(tx_irq));

	cantx_engine_model u_eng (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .lat_i(lat),
		.bit_per_i(bit_per), .done_o(done_w), .bit_tick_o(bit_tick));
	////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
		n_tests++;
		if (g < lo || g > hi) begin
			errors++;
			$display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask : chk_rng

	task automatic hang;
		errors++;
		stop_test();
	endtask : hang

	// Setup, then access held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) hang();
		rd = prdata;
		err_s = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask : apb

	task automatic send(input cantx_kind_t kd, input logic [5:0] ix, input logic ab, em, lg);
		int k;
		req <= '{1'b1, kd, ix, ab, em, lg};
		lat <= 4'($urandom_range(0, 5));
		@(posedge clk_i);
		req.valid <= 1'b0;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (done_w.valid !== 1'b1 && k < 32);
		if (done_w.valid !== 1'b1) hang();
		@(posedge clk_i);
	endtask : send

	task automatic qpush(input cantx_src_t s, input logic [1:0] q, input logic [28:0] id);
		push <= '{1'b1, s, q, id};
		@(posedge clk_i);
		push.valid <= 1'b0;
		@(negedge clk_i);
		ok_s = push_ok;
		dr_s = push_drop;
		bf_s = push_buf;
		@(posedge clk_i);
	endtask : qpush

	function automatic logic [31:0] fcfg(input cantx_mode_t m, input logic im,
		input logic [1:0] s, input logic [5:0] lk, input logic [7:0] b);
		return {8'h00, b, 2'h0, lk, 2'h0, s, im, m, 1'b1};
	endfunction : fcfg

	function automatic logic [5:0] qslot(input int q, input int i);
		case (q)
			0: return 6'(i);
			1: return 6'(31 - i);
			2: return 6'(32 + i);
			default: return 6'(63 - i);
		endcase
	endfunction : qslot
	////////////////////////////////////////////////////////////
	initial begin
		errors = 0;
		n_tests = 0;
		rst_i = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		req = '0;
		push = '0;
		lat = 4'h0;
		bit_per = 8'h07;
		srcs = '{2'h0, 2'h2, 2'h1, 2'h3};
		void'($urandom(32'h3739));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("rx at reset", 32'h7, 32'(fifo_rx));
		apb(1'b0, A_PRESC, 32'h0);
		chk("prescaler", 32'h1, rd);
		apb(1'b0, 12'h034, 32'h0);
		chk("unmapped err", 32'h1, 32'(err_s));
		chk("unmapped data", 32'h0, rd);
		// Interval for every count source; short figures keep the run brief
		foreach (srcs[i]) begin
			presc = 2 + $urandom_range(0, 1);
			mult = 2 + $urandom_range(0, 2);
			apb(1'b1, A_PRESC, 32'(presc));
			apb(1'b1, A_FIFO0, fcfg(M_TX, 1'b1, srcs[i], 6'(i), 8'(mult)));
			chk("link", 32'(i), 32'(fifo_link[0]));
			chk("go idle", 32'h1, 32'(fifo_go[0]));
			send(K_FIFO, 6'h00, 1'b0, 1'b0, 1'b0);
			@(negedge clk_i);
			chk("go held", 32'h0, 32'(fifo_go[0]));
			n = 2;
			@(posedge clk_i);
			while (fifo_go[0] !== 1'b1 && n < 2000) begin
				@(posedge clk_i);
				n++;
			end
			if (n == 2000) hang();
			t = srcs[i][0] ? 7 : (srcs[i][1] ? 20 * presc : 2 * presc);
			chk_rng("interval", (mult - 1) * t, mult * t + 4, n);
		end
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, 12'h008, fcfg(cantx_mode_t'(m), 1'b1, 2'h0, 6'h05, 8'h00));
			chk("rx flag", 32'(m == 0), 32'(fifo_rx[1]));
			chk("go by mode", 32'(m != 0), 32'(fifo_go[1]));
		end
		apb(1'b1, A_STAT, 32'h1F);
		send(K_FIFO, 6'h01, 1'b0, 1'b0, 1'b0);
		apb(1'b0, A_STAT, 32'h0);
		chk("fifo every", 32'h4, rd & 32'h4);
		apb(1'b1, 12'h008, fcfg(M_TX, 1'b0, 2'h0, 6'h05, 8'h00));
		apb(1'b1, A_STAT, 32'h1F);
		send(K_FIFO, 6'h01, 1'b0, 1'b0, 1'b0);
		apb(1'b0, A_STAT, 32'h0);
		chk("fifo not empty", 32'h0, rd & 32'h4);
		send(K_FIFO, 6'h01, 1'b0, 1'b1, 1'b0);
		chk("irq fifo", 32'h1, 32'(tx_irq));
		// Buffer 40 enabled, 41 masked
		apb(1'b1, A_IEN_HI, 32'h0000_0100);
		apb(1'b1, A_STAT, 32'h1F);
		send(K_BUF, 6'h29, 1'b0, 1'b0, 1'b0);
		chk("masked", 32'h0, 32'(tx_irq));
		send(K_BUF, 6'h28, 1'b0, 1'b0, 1'b0);
		send(K_BUF, 6'h28, 1'b1, 1'b0, 1'b0);
		apb(1'b0, A_STAT, 32'h0);
		chk("done abort", 32'h3, rd);
		apb(1'b1, A_STAT, 32'h3);
		chk("irq cleared", 32'h0, 32'(tx_irq));
		apb(1'b1, A_IEN_HI, 32'h0);
		// Queues: fill, overflow, overwrite, source refusal, pops
		for (int q = 0; q < 4; q++) begin
			id0 = 29'($urandom);
			cs = (q == 3) ? S_DMA : S_GW;
			apb(1'b1, A_QUEUE0 + 12'(4 * q), 32'(32'h301 | ((q != 1) << 2) | ((q == 2) << 1)));
			for (int i = 0; i < 3; i++) begin
				qpush(cs, 2'(q), id0 + 29'(i));
				chk("push ok", 32'h1, 32'(ok_s));
				chk("slot", 32'(qslot(q, i)), 32'(bf_s));
			end
			chk("head", 32'(qslot(q, 0)), 32'(q_head[q]));
			qpush(cs, 2'(q), id0 + 29'h3);
			chk("full drop", 32'h1, 32'(dr_s));
			qpush(cs, 2'(q), id0 + 29'h1);
			chk("same id", 32'(q != 1), 32'(ok_s));
			if (q != 1) chk("overwrite slot", 32'(qslot(q, 1)), 32'(bf_s));
			qpush((q == 3) ? S_GW : S_DMA, 2'(q), id0 + 29'h9);
			chk("source drop", 32'h1, 32'(dr_s));
			apb(1'b0, A_QUEUE0 + 12'(4 * q), 32'h0);
			chk("count", 32'h3, 32'(rd[21:16]));
			for (int i = 0; i < 3; i++) begin
				send(K_QUEUE, 6'(q), 1'b0, 1'(i == 2), 1'b0);
				apb(1'b0, A_STAT, 32'h0);
				chk("queue irq", (q == 2 || i == 2) ? 32'h8 : 32'h0, rd & 32'h8);
			end
			chk("emptied", 32'h0, 32'(q_busy[q]));
			apb(1'b1, A_STAT, 32'h1F);
		end
		apb(1'b1, A_QUEUE0, 32'h0000_0201);
		qpush(S_CPU, 2'h0, id0);
		chk("depth two", 32'h1, 32'(dr_s));
		// History: selection, flag, abort, three quarters, capacity
		apb(1'b1, A_HIST, 32'h1);
		send(K_BUF, 6'h07, 1'b0, 1'b0, 1'b1);
		send(K_FIFO, 6'h02, 1'b0, 1'b0, 1'b1);
		send(K_FIFO, 6'h02, 1'b0, 1'b0, 1'b0);
		send(K_FIFO, 6'h02, 1'b1, 1'b0, 1'b1);
		apb(1'b0, A_HIST, 32'h0);
		chk("hist count", 32'h1, 32'(rd[14:8]));
		apb(1'b0, A_HDATA, 32'h0);
		chk("hist entry", 32'h142, 32'(rd[8:0]));
		apb(1'b1, A_HIST, 32'h3);
		apb(1'b1, A_STAT, 32'h1F);
		for (int i = 1; i <= 70; i++) begin
			send(K_BUF, 6'($urandom_range(0, 63)), 1'b0, 1'b0, 1'b1);
			if (i == 47 || i == 48) begin
				apb(1'b0, A_STAT, 32'h0);
				chk("hist 3/4", (i == 48) ? 32'h10 : 32'h0, rd & 32'h10);
			end
		end
		apb(1'b0, A_HIST, 32'h0);
		chk("hist full", 32'h40, 32'(rd[14:8]));
		apb(1'b1, A_HIST, 32'h7);
		apb(1'b1, A_STAT, 32'h1F);
		apb(1'b0, A_HDATA, 32'h0);
		send(K_FIFO, 6'h02, 1'b0, 1'b0, 1'b1);
		apb(1'b0, A_STAT, 32'h0);
		chk("hist every", 32'h10, rd & 32'h10);
		stop_test();
	end
endmodule : cantx_top_tb
